//--- rtl/pll_clock_mode_control.sv
// pll clock mode control: lock timing, rate decode and clock output gating
// assumes a wishbone classic master and asynchronous reference pins
// What the document requires of this block and its host
// R1: with power enable set, clocks come from the pll per reference and rate
// R2: reference 0000 frame clock 1fs, 0010 bit clock 32fs, 0011 bit 64fs
// R3: reference 1001 is default, 12MHz master clock, lower jitter than 0110
// R4: master clock codes map to nine input frequencies; others unsupported
// R5: lock within 80ms frame, 2 or 4ms bit, 40 or 60ms master clock
// R6: host waits the longest lock time before trusting clocks or samples
// R7: host gives a stable reference; lock time counts from stable reference
// R8: master clock reference decodes rate codes to twelve sample rates
// R9: with reference 1001 the 44.1kHz family runs slightly low
// R10: pin references use only upper two rate bits as a range
// R11: master mode after power enable, bit and frame clocks low until lock
// R12: unlocked master clock output irregular if enabled, low if disabled
// R13: dsp mode 0, first frame after lock carries left channel
// R14: first bit clock high shortened by 1/256fs when msb start differs
// R15: host clears power enable for rate change; bit and frame go low
// R16: relock makes bit and frame invalid; locked frame runs at 1fs
// R17: slave master clock output invalid before lock, divided after lock; held low here with a pin reference
// R18: slave samples invalid while pll unlocked
// R19: master select one is master, zero is slave; slave after reset
// R20: master clock divider 00 256fs, 01 128fs, 10 64fs, 11 32fs
// R21: bit clock ratio 01 32fs, 10 64fs; 00 and 11 unsupported
//
// The implementer's own choices: the address map and the Wishbone interface to the registers.
`default_nettype none

module pll_clock_mode_control
  import pll_clock_pkg::*;
#(
  parameter int unsigned FRAME_LOCK_CYCLES =
    pll_clock_pkg::FRAME_LOCK_MS * pll_clock_pkg::CYCLES_PER_MS,
  parameter int unsigned BIT_SHORT_CYCLES =
    pll_clock_pkg::BIT_LOCK_SHORT_MS * pll_clock_pkg::CYCLES_PER_MS,
  parameter int unsigned BIT_LONG_CYCLES =
    pll_clock_pkg::BIT_LOCK_LONG_MS * pll_clock_pkg::CYCLES_PER_MS,
  parameter int unsigned MASTER_CLOCK_INPUT_LOCK_CYCLES =
    pll_clock_pkg::MASTER_CLOCK_INPUT_LOCK_MS * pll_clock_pkg::CYCLES_PER_MS,
  parameter int unsigned MASTER_CLOCK_INPUT_SLOW_CYCLES =
    pll_clock_pkg::MASTER_CLOCK_INPUT_SLOW_MS * pll_clock_pkg::CYCLES_PER_MS
) (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  input  wire logic        master_clock_input,
  input  wire logic        bit_clock_in,
  input  wire logic        frame_clock_in,
  output var  logic        master_clock_output,
  output var  logic        bit_clock_out,
  output var  logic        bit_clock_oe,
  output var  logic        frame_clock_out,
  output var  logic        frame_clock_oe,
  output var  logic        samples_valid
);

  import pll_clock_pkg::*;

  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[8*i +: 8] = new_v[8*i +: 8];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register bus

  logic [31:0]   control_reg;
  logic [31:0]   select_reg;
  logic          ack_next;
  logic [31:0]   rdata_next;
  logic          bus_req;
  logic          wr_control;
  logic          wr_select;
  logic [31:0]   select_next;
  logic          restart;
  pll_state_type state_reg;
  pll_state_type state_next;
  logic          ref_active;
  logic          config_ok;
  logic [31:0]   status_word;

  assign bus_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign ack_next   = bus_req;
  assign wr_control = bus_req & wb_we_i
                      & wb_adr_i[7:2] == CONTROL_OFFSET[7:2];
  assign wr_select  = bus_req & wb_we_i
                      & wb_adr_i[7:2] == SELECT_OFFSET[7:2];
  assign select_next = lane_merge(select_reg, wb_dat_i, wb_sel_i)
                       & SELECT_MASK;
  assign status_word = {27'h0, samples_valid, ~config_ok, ref_active,
                        state_reg == S_RELOCK || state_reg == S_FIRST,
                        state_reg == S_LOCKED};
  assign rdata_next =
    wb_adr_i[7:2] == CONTROL_OFFSET[7:2] ? control_reg :
    wb_adr_i[7:2] == SELECT_OFFSET[7:2]  ? select_reg  :
    wb_adr_i[7:2] == STATUS_OFFSET[7:2]  ? status_word : 32'h0000_0000;

  // a change of reference or rate while running forces a new acquisition
  assign restart = wr_select & (select_next != select_reg)
                   & state_reg != S_OFF;                          // R5

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      control_reg <= CONTROL_RESET;                               // R19
      select_reg  <= SELECT_RESET;                                // R3
      wb_ack_o    <= 1'b0;
      wb_dat_o    <= 32'h0000_0000;
    end else begin
      wb_ack_o <= ack_next;
      if (bus_req) wb_dat_o <= rdata_next;
      if (wr_control)
        control_reg <= lane_merge(control_reg, wb_dat_i, wb_sel_i)
                       & CONTROL_MASK;
      if (wr_select) select_reg <= select_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // field decode

  logic       power_en;
  logic       master_sel;
  logic       mck_en;
  logic       filter_long;
  logic       dsp_mode0;
  logic       dsp_msb_start_select;
  logic       bit_clock_polarity;
  logic [1:0] master_clock_out_divider;
  logic [1:0] bit_clock_ratio_select;
  logic [3:0] pll_reference_select;
  logic [3:0] sample_rate_select;
  logic       ref_pin;
  logic       ratio_ok;
  logic [63:0] fs_millihz;
  logic [ACC_WIDTH-1:0] step;

  assign power_en    = control_reg[CTL_POWER];
  assign master_sel  = control_reg[CTL_MASTER];
  assign mck_en      = control_reg[CTL_MCK_EN];
  assign filter_long = control_reg[CTL_FILTER];
  assign dsp_mode0   = control_reg[CTL_DSP0];
  assign dsp_msb_start_select = control_reg[CTL_MSB];
  assign bit_clock_polarity   = control_reg[CTL_POL];
  assign master_clock_out_divider = control_reg[CTL_DIV_LSB +: 2];
  assign bit_clock_ratio_select   = control_reg[CTL_BCK_LSB +: 2];
  assign pll_reference_select = select_reg[SEL_REF_LSB +: 4];
  assign sample_rate_select   = select_reg[SEL_RATE_LSB +: 4];

  assign ref_pin    = ref_is_pin(pll_reference_select);          // R2
  assign fs_millihz = rate_millihz(pll_reference_select,
                                   sample_rate_select);    // R8 R9 R10
  assign step       = rate_step(fs_millihz);                      // R1
  assign ratio_ok   = bit_clock_ratio_select == BCK_32FS
                      || bit_clock_ratio_select == BCK_64FS;      // R21
  // a pin reference cannot be used while this end drives those pins
  assign config_ok  = ref_supported(pll_reference_select)         // R4
                      && fs_millihz != 64'd0
                      && !(master_sel && (ref_pin || !ratio_ok));

  ////////////////////////////////////////////////////////////////////////////
  // reference activity

  logic [2:0] pin_meta_reg;
  logic [2:0] pin_sync_reg;
  logic       ref_level;
  logic       ref_prev_reg;
  logic [8:0] stale_reg;

  assign ref_level =
    pll_reference_select == REF_FRAME ? pin_sync_reg[2] :
    ref_pin                           ? pin_sync_reg[1] : pin_sync_reg[0];
  assign ref_active = stale_reg < 9'(REF_STALE_CYCLES);

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pin_meta_reg <= 3'h0;
      pin_sync_reg <= 3'h0;
      ref_prev_reg <= 1'b0;
      stale_reg    <= 9'(REF_STALE_CYCLES);
    end else begin
      pin_meta_reg <= {frame_clock_in, bit_clock_in, master_clock_input};
      pin_sync_reg <= pin_meta_reg;
      ref_prev_reg <= ref_level;
      if (ref_level != ref_prev_reg) stale_reg <= 9'h000;
      else if (!ref_active) stale_reg <= stale_reg;
      else stale_reg <= stale_reg + 9'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // lock sequencing

  logic [TIMER_WIDTH-1:0] timer_reg;
  logic [TIMER_WIDTH-1:0] lock_target;
  logic                   timer_done;
  logic                   counting;
  logic                   master_clock_input_slow;

  assign master_clock_input_slow = pll_reference_select[3:1] == 3'h7;
  assign lock_target = TIMER_WIDTH'(
    pll_reference_select == REF_FRAME ? FRAME_LOCK_CYCLES :
    ref_pin   ? (filter_long ? BIT_LONG_CYCLES : BIT_SHORT_CYCLES) :
    master_clock_input_slow ? MASTER_CLOCK_INPUT_SLOW_CYCLES : MASTER_CLOCK_INPUT_LOCK_CYCLES);            // R5
  // counting only runs on a present reference and a usable setting
  assign counting   = (state_reg == S_FIRST || state_reg == S_RELOCK)
                      && ref_active && config_ok && !restart;     // R7
  assign timer_done = counting && timer_reg >= lock_target - 1'b1;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      S_OFF:    if (power_en) state_next = S_FIRST;               // R1
      S_FIRST:  if (timer_done) state_next = S_LOCKED;
      S_RELOCK: if (timer_done) state_next = S_LOCKED;
      S_LOCKED: if (restart || !config_ok) state_next = S_RELOCK;
      default:  state_next = S_OFF;
    endcase
    if (!power_en) state_next = S_OFF;                            // R15
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_reg <= S_OFF;
      timer_reg <= '0;
    end else begin
      state_reg <= state_next;
      timer_reg <= counting && !timer_done ? timer_reg + 1'b1 : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock generation

  logic       tick;
  logic [8:0] phase_reg;
  logic       lock_entry;
  logic       bclk_pol;
  logic       first_pulse_reg;
  logic [1:0] hi_ticks_reg;
  logic       short_mask;
  logic       bit_gen;
  logic       frame_gen;
  logic       mck_gen;

  rate_tick_gen #(
    .WIDTH (ACC_WIDTH)
  ) u_tick (
    .clock  (clock),
    .reset  (reset),
    .enable (state_reg != S_OFF && config_ok),
    .step   (step),
    .tick   (tick)
  );

  assign lock_entry = state_next == S_LOCKED && state_reg != S_LOCKED;
  assign bclk_pol   = (bit_clock_ratio_select == BCK_64FS ? phase_reg[2]
                       : phase_reg[3]) ^ bit_clock_polarity;      // R21
  assign short_mask = first_pulse_reg && hi_ticks_reg < SHORT_TICKS;
  assign bit_gen    = state_reg == S_LOCKED ? bclk_pol & ~short_mask
                    : state_reg == S_RELOCK ? bclk_pol : 1'b0;    // R16
  // phase zero opens the left half of the frame
  assign frame_gen  = state_reg == S_LOCKED || state_reg == S_RELOCK
                      ? ~phase_reg[8] : 1'b0;                     // R13
  assign mck_gen    = phase_reg[master_clock_out_divider];        // R20

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      phase_reg       <= 9'h000;
      first_pulse_reg <= 1'b0;
      hi_ticks_reg    <= 2'h0;
    end else begin
      if (lock_entry) phase_reg <= 9'h000;                        // R13
      else if (tick) phase_reg <= phase_reg + 9'h001;
      if (lock_entry) begin
        first_pulse_reg <= dsp_mode0
                           & (dsp_msb_start_select ^ bit_clock_polarity);
        hi_ticks_reg    <= 2'h0;                                  // R14
      end else if (first_pulse_reg && tick) begin
        if (bclk_pol && hi_ticks_reg < SHORT_TICKS)
          hi_ticks_reg <= hi_ticks_reg + 2'h1;
        else if (!bclk_pol && hi_ticks_reg != 2'h0)
          first_pulse_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin outputs

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      master_clock_output <= 1'b0;
      bit_clock_out       <= 1'b0;
      bit_clock_oe        <= 1'b0;
      frame_clock_out     <= 1'b0;
      frame_clock_oe      <= 1'b0;
      samples_valid       <= 1'b0;
    end else begin
      master_clock_output <= mck_en && state_reg != S_OFF
                             && !(ref_pin && !master_sel)
                             && mck_gen;                   // R12 R17
      bit_clock_out   <= master_sel & bit_gen;                    // R11
      bit_clock_oe    <= master_sel;                              // R19
      frame_clock_out <= master_sel & frame_gen;                  // R11
      frame_clock_oe  <= master_sel;
      samples_valid   <= state_reg == S_LOCKED;                   // R18
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  first_acq_low_a: assert property ( // R11
    state_reg == S_FIRST |=> !bit_clock_out && !frame_clock_out)
    else $error("bit or frame clock active before first lock");

  off_low_a: assert property ( // R15
    !power_en ##1 state_reg == S_OFF |=> !bit_clock_out && !frame_clock_out)
    else $error("bit or frame clock active with pll off");

  mck_disabled_a: assert property ( // R12
    !mck_en |=> !master_clock_output)
    else $error("master clock output active while disabled");

  valid_lock_a: assert property ( // R18
    samples_valid == $past(state_reg == S_LOCKED))
    else $error("sample valid does not follow lock");

  pin_dir_a: assert property ( // R19
    ##1 bit_clock_oe == $past(master_sel) && frame_clock_oe == bit_clock_oe)
    else $error("pin enable does not follow master select");

  lock_time_a: assert property ( // R5
    $rose(state_reg == S_LOCKED) |->
      $past(timer_reg) == $past(lock_target) - 1'b1)
    else $error("lock reached at wrong count");

  left_first_a: assert property ( // R13
    $rose(state_reg == S_LOCKED) && master_sel |=>
      frame_clock_out && phase_reg[8:3] == 6'h00)
    else $error("first frame after lock is not left");

  short_pulse_a: assert property ( // R14
    short_mask && master_sel && state_reg == S_LOCKED |=> !bit_clock_out)
    else $error("first bit clock pulse not shortened");

  unsupported_a: assert property ( // R4
    !config_ok && state_reg != S_LOCKED |=> state_reg != S_LOCKED)
    else $error("locked with unsupported setting");

endmodule

`default_nettype wire

//--- rtl/pll_clock_pkg.sv
// constants, state type and decode functions of the pll clock control
// assumes a 200 MHz system clock and a 32-bit wishbone register bus
`default_nettype none

package pll_clock_pkg;

  localparam int unsigned CLOCK_HZ          = 200_000_000;
  localparam int unsigned CYCLES_PER_MS     = CLOCK_HZ / 1000;
  localparam int unsigned FRAME_LOCK_MS     = 80;
  localparam int unsigned BIT_LOCK_SHORT_MS = 2;
  localparam int unsigned BIT_LOCK_LONG_MS  = 4;
  localparam int unsigned MASTER_CLOCK_INPUT_LOCK_MS      = 40;
  localparam int unsigned MASTER_CLOCK_INPUT_SLOW_MS      = 60;
  localparam int unsigned TIMER_WIDTH       = 25;
  localparam int unsigned REF_STALE_CYCLES  = 256;
  localparam int unsigned ACC_WIDTH         = 24;
  localparam int unsigned TICKS_PER_FS      = 512;
  localparam logic [1:0]  SHORT_TICKS       = 2'h2;

  localparam logic [7:0]  CONTROL_OFFSET = 8'h00;
  localparam logic [7:0]  SELECT_OFFSET  = 8'h04;
  localparam logic [7:0]  STATUS_OFFSET  = 8'h08;

  localparam int unsigned CTL_POWER    = 0;
  localparam int unsigned CTL_MASTER   = 1;
  localparam int unsigned CTL_MCK_EN   = 2;
  localparam int unsigned CTL_FILTER   = 3;
  localparam int unsigned CTL_DSP0     = 4;
  localparam int unsigned CTL_MSB      = 5;
  localparam int unsigned CTL_POL      = 6;
  localparam int unsigned CTL_DIV_LSB  = 8;
  localparam int unsigned CTL_BCK_LSB  = 10;
  localparam int unsigned SEL_REF_LSB  = 0;
  localparam int unsigned SEL_RATE_LSB = 4;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0400;
  localparam logic [31:0] SELECT_RESET  = 32'h0000_00F9;
  localparam logic [31:0] CONTROL_MASK  = 32'h0000_0F7F;
  localparam logic [31:0] SELECT_MASK   = 32'h0000_00FF;

  localparam logic [3:0] REF_FRAME    = 4'h0;
  localparam logic [3:0] REF_BIT32    = 4'h2;
  localparam logic [3:0] REF_BIT64    = 4'h3;
  localparam logic [3:0] REF_MASTER_CLOCK_INPUT_ADJ = 4'h9;
  localparam logic [1:0] BCK_32FS     = 2'h1;
  localparam logic [1:0] BCK_64FS     = 2'h2;

  typedef enum logic [3:0] {
    S_OFF    = 4'b0001,
    S_FIRST  = 4'b0010,
    S_RELOCK = 4'b0100,
    S_LOCKED = 4'b1000
  } pll_state_type;

  function automatic logic ref_is_pin(input logic [3:0] ref_code);
    return ref_code == REF_FRAME || ref_code == REF_BIT32
           || ref_code == REF_BIT64;
  endfunction

  // sample rate in millihertz, zero when unsupported
  function automatic logic [63:0] rate_millihz(input logic [3:0] ref_code,
                                               input logic [3:0] rate);
    logic adj;
    adj = ref_code == REF_MASTER_CLOCK_INPUT_ADJ;
    if (ref_is_pin(ref_code)) begin
      if (rate[3])      return 64'd48000000;
      else if (rate[2]) return 64'd24000000;
      else              return 64'd12000000;
    end
    case (rate)
      4'h0:    return 64'd8000000;
      4'h1:    return 64'd12000000;
      4'h2:    return 64'd16000000;
      4'h3:    return 64'd24000000;
      4'h4:    return adj ? 64'd7349918  : 64'd7350000;
      4'h5:    return adj ? 64'd11024877 : 64'd11025000;
      4'h6:    return adj ? 64'd14699840 : 64'd14700000;
      4'h7:    return adj ? 64'd22049750 : 64'd22050000;
      4'hA:    return 64'd32000000;
      4'hB:    return 64'd48000000;
      4'hE:    return adj ? 64'd29399670 : 64'd29400000;
      4'hF:    return adj ? 64'd44099500 : 64'd44100000;
      default: return 64'd0;
    endcase
  endfunction

  function automatic logic ref_supported(input logic [3:0] ref_code);
    return ref_is_pin(ref_code) || ref_code[3:2] == 2'h1
           || ref_code == 4'h8 || ref_code == 4'h9 || ref_code[3:2] == 2'h3;
  endfunction

  // accumulator step giving TICKS_PER_FS ticks per sample period
  function automatic logic [ACC_WIDTH-1:0] rate_step(input logic [63:0] mhz);
    logic [63:0] prod;
    prod = (mhz * 64'(TICKS_PER_FS)) << ACC_WIDTH;
    return ACC_WIDTH'(prod / (64'(CLOCK_HZ) * 64'd1000));
  endfunction

endpackage

`default_nettype wire

//--- rtl/rate_tick_gen.sv
// phase accumulator giving one tick per carry
// assumes step well below half the accumulator range
`default_nettype none

module rate_tick_gen #(
  parameter int unsigned WIDTH = 24
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             enable,
  input  wire logic [WIDTH-1:0] step,
  output var  logic             tick
);

  logic [WIDTH:0] acc_next;
  logic [WIDTH-1:0] acc_reg;

  assign acc_next = {1'b0, acc_reg} + {1'b0, step};

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      acc_reg <= '0;
      tick    <= 1'b0;
    end else begin
      acc_reg <= enable ? acc_next[WIDTH-1:0] : '0;
      tick    <= enable & acc_next[WIDTH];
    end
  end

endmodule

`default_nettype wire

//--- tb/serial_port_partner.sv
// far-side partner: sources master, bit and frame reference clocks
// assumes the 200 MHz bench clock; a released pin is pulled low
`default_nettype none

module serial_port_partner (
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic released,
  output var  logic master_clock_input,
  output var  logic bit_clock,
  output var  logic frame_clock
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] phase_reg;

  // free running divider keeps every reference stable and periodic while not released
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      phase_reg <= 8'h00;
    end else begin
      phase_reg <= phase_reg + 8'h01;
    end
  end

  assign master_clock_input = phase_reg[1];
  assign bit_clock          = released ? 1'b0 : phase_reg[2];
  assign frame_clock        = released ? 1'b0 : phase_reg[7];
endmodule

`default_nettype wire

//--- tb/tb.sv
// self-checking bench for pll_clock_mode_control
// assumes serial_port_partner and shortened lock counts
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pll_clock_pkg::*;

`define CHECK(name, exp, got) begin \
  comparisons++; \
  if ((got) !== (exp)) begin \
    failures++; \
    $display("Error %s expected %0h seen %0h", name, exp, got); \
  end \
end

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] sel;
    int          wait_n;
    logic        lock;
  } row_type;

  logic        clock, reset, cyc, stb, we, ack, bad;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, q;
  logic        mck_in, bck_far, fck_far, mck_out, valid;
  logic        bck_out, bck_oe, fck_out, fck_oe;
  wire logic   bck_pin = bck_oe ? bck_out : bck_far;
  wire logic   fck_pin = fck_oe ? fck_out : fck_far;
  int          failures, comparisons, n;
  row_type     rows [11];

  pll_clock_mode_control #(
    .FRAME_LOCK_CYCLES(100), .BIT_SHORT_CYCLES(60), .BIT_LONG_CYCLES(80),
    .MASTER_CLOCK_INPUT_LOCK_CYCLES(120), .MASTER_CLOCK_INPUT_SLOW_CYCLES(150)
  ) dut_u (
    .clock(clock), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .master_clock_input(mck_in),
    .bit_clock_in(bck_pin), .frame_clock_in(fck_pin),
    .master_clock_output(mck_out), .bit_clock_out(bck_out),
    .bit_clock_oe(bck_oe), .frame_clock_out(fck_out),
    .frame_clock_oe(fck_oe), .samples_valid(valid)
  );

  serial_port_partner partner_u (
    .clock(clock), .reset(reset), .released(bck_oe),
    .master_clock_input(mck_in), .bit_clock(bck_far), .frame_clock(fck_far)
  );

  always #2.5 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////
  task automatic wb_cycle(input logic w, input logic [7:0] a,
                          input logic [31:0] d, input logic [3:0] s);
    int k;
    @(posedge clock);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= s;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (ack !== 1'b1 && k < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    `CHECK("wb_ack", 1'b1, ack)
  endtask

  // counts master and bit clock rises over one whole frame
  task automatic per_frame(input int mck, input int bck);
    logic pf, pm, pb;
    int m, b, k, ph;
    m = 0;
    b = 0;
    ph = 0;
    pf = fck_out;
    pm = mck_out;
    pb = bck_out;
    for (k = 0; k < 12000 && ph < 2; k++) begin
      @(posedge clock);
      if (ph == 1 && mck_out && !pm) m++;
      if (ph == 1 && bck_out && !pb) b++;
      if (fck_out && !pf) ph++;
      pf = fck_out;
      pm = mck_out;
      pb = bck_out;
    end
    `CHECK("mck_rate", 1'b1, (m >= mck - 1 && m <= mck + 1))
    `CHECK("bck_rate", 1'b1, (b >= bck - 1 && b <= bck + 1))
    `CHECK("frame_rate", 2, ph)
  endtask

  task automatic give_verdict;
    $display("Comparisons %0d, failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (80000) @(posedge clock);
    failures++;
    give_verdict();
  end

  initial begin
    clock = 1'b0;
    reset = 1'b1;
    {cyc, stb, we, adr, sel, wdat} = '0;
    rows[0] = '{32'h0000_0401, 32'h0000_00F9, 120, 1'b1};
    rows[1] = '{32'h0000_0401, 32'h0000_00BE, 150, 1'b1};
    rows[2] = '{32'h0000_0401, 32'h0000_0080, 100, 1'b1};
    rows[3] = '{32'h0000_0409, 32'h0000_0082, 80, 1'b1};
    rows[4] = '{32'h0000_0401, 32'h0000_0043, 60, 1'b1};
    rows[5] = '{32'h0000_0401, 32'h0000_00F1, 300, 1'b0};
    rows[6] = '{32'h0000_0401, 32'h0000_0089, 300, 1'b0};
    rows[7] = '{32'h0000_0403, 32'h0000_0080, 300, 1'b0};
    rows[8] = '{32'h0000_0003, 32'h0000_00F9, 300, 1'b0};
    rows[9] = '{32'h0000_0407, 32'h0000_00B5, 120, 1'b1};
    rows[10] = '{32'h0000_0457, 32'h0000_00B5, 120, 1'b1};
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    `CHECK("idle_pins", 3'h0, {mck_out, bck_oe, fck_oe})
    wb_cycle(1'b0, 8'h00, 32'h0, 4'hF);
    `CHECK("control_reset", 32'h0000_0400, q)
    wb_cycle(1'b0, 8'h04, 32'h0, 4'hF);
    `CHECK("select_reset", 32'h0000_00F9, q)
    wb_cycle(1'b1, 8'h0C, 32'hFFFF_FFFF, 4'hF);
    wb_cycle(1'b0, 8'h0C, 32'h0, 4'hF);
    `CHECK("unmapped", 32'h0, q)
    wb_cycle(1'b1, 8'h04, 32'h0000_0012, 4'h2);
    wb_cycle(1'b0, 8'h04, 32'h0, 4'hF);
    `CHECK("lane_merge", 32'h0000_00F9, q)
    foreach (rows[i]) begin
      wb_cycle(1'b1, 8'h00, 32'h0, 4'hF);
      wb_cycle(1'b1, 8'h04, rows[i].sel, 4'hF);
      `CHECK("power_off", 1'b0, valid)
      wb_cycle(1'b1, 8'h00, rows[i].ctrl, 4'hF);
      n = 0;
      bad = 1'b0;
      while (valid !== 1'b1 && n < rows[i].wait_n + 300) begin
        @(posedge clock);
        n++;
        // frame clock rises together with valid, so only look before it
        bad |= ~valid & (((bck_out | fck_out) & bck_oe)
                         | (mck_out & ~rows[i].ctrl[2]));
      end
      `CHECK("locked", rows[i].lock, valid)
      `CHECK("quiet_pins", 1'b0, bad)
      `CHECK("pin_drive", rows[i].ctrl[1], bck_oe)
      if (rows[i].lock) `CHECK("lock_time", rows[i].wait_n + 2, n)
      wb_cycle(1'b0, 8'h08, 32'h0, 4'hF);
      `CHECK("unsupported", ~rows[i].lock, q[3])
    end
    for (int d = 0; d < 4; d++) begin
      wb_cycle(1'b1, 8'h00, {20'h0, d[0] ? 2'h2 : 2'h1, d[1:0], 8'h07}, 4'hF);
      per_frame(256 >> d, d[0] ? 64 : 32);
    end
    // a rate change while locked forces a new acquisition
    wb_cycle(1'b1, 8'h04, 32'h0000_00A5, 4'hF);
    wb_cycle(1'b0, 8'h08, 32'h0, 4'hF);
    `CHECK("relock_status", 5'h06, q[4:0])
    n = 0;
    while (valid !== 1'b1 && n < 500) begin
      @(posedge clock);
      n++;
    end
    `CHECK("relocked", 1'b1, valid)
    `CHECK("frame_drive", 1'b1, fck_oe)
    reset <= 1'b1;
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    `CHECK("reset_again", 2'h0, {valid, bck_oe})
    give_verdict();
  end
endmodule

`default_nettype wire
